// ==== verilog/strobe_port_pkg.sv ====
/*
 * constants, state codes and carrier types for the split-strobe host port.
 * assumes a system clock of 20 MHz and a host bus clock on a pin of its own.
 */
package strobe_port_pkg;

    // reset-time configuration
    localparam logic [2:0]  STRAP_GENERIC    = 3'h7;
    localparam logic [1:0]  CATCH_LAST       = 2'h3;

    // host window map
    localparam logic [15:0] MEM_END          = 16'h9fff;
    localparam logic [15:0] REG_BASE         = 16'hffe0;
    localparam logic [15:0] MEM_HALF_WORDS   = 16'h5000;
    localparam int          MEM_WORDS_DOC    = 40960;
    localparam int          REG_WORDS        = 16;

    // register word indices and field positions
    localparam logic [3:0]  REG_CONTROL      = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h1;
    localparam int          CTL_PANEL_POWER  = 0;
    localparam int          CTL_PIXEL_DIV    = 1;
    localparam logic [15:0] CONTROL_RESET    = 16'h0000;

    // host-domain cycle states
    typedef enum logic [2:0] {
        HOST_IDLE = 3'b001,
        HOST_WAIT = 3'b010,
        HOST_DONE = 3'b100
    } host_state_t;

    // one host access held stable while it crosses to the system clock
    typedef struct packed {
        logic        top;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
        logic        write;
    } host_req_t;

    // straps as caught after reset
    typedef struct packed {
        logic       bus_status_n;
        logic       big_endian;
        logic [2:0] mode;
    } strap_t;

endpackage

// ==== verilog/level_sync.sv ====
/*
 * two-flop synchroniser for a group of independent levels.
 * assumes each bit is a level or a toggle that changes slowly against clk_i.
 */
module level_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    if (WIDTH < 1)
    begin : g_check
        $error("level_sync needs WIDTH of at least one");
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_r <= RESET_VAL;
            q_r    <= RESET_VAL;
        end
        else
        begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule

// ==== verilog/strobe_host_port.sv ====
/*
 * split-strobe 16-bit host port with display memory, register file,
 * refresh arbitration, strap capture and pixel clock divider.
 * assumes the board decodes chip select and strobes, ties the bus status
 * and read/write lines high, and that refresh requests come on clk_sys_i.
 */
// What this block does
// RL1: catch mode straps during reset (caught just after release here); 111 selects a general strobe mode.
// RL2: board holds bus status high for split strobe; line unused in cycles.
// RL3: endian strap at reset fixes byte order, high big, low little.
// RL4: host transfers are timed by the host bus clock, apart from pixels.
// RL5: strobes and select may be unrelated in phase to the bus clock.
// RL6: sixteen address inputs and sixteen two-way data lines to the host.
// RL7: wide big-endian hosts use high data lanes, others low lanes.
// RL8: host decodes its high address lines into the active-low select.
// RL9: high byte enable picks upper byte; write enable requests a write.
// RL10: glue holds read enable low through each whole host read.
// RL11: hold-off low while a cycle cannot finish, released when data ready.
// RL12: arbitrate host against refresh, holding off until granted.
// RL13: read/write line tied high and ignored, like bus status.
// RL14: display memory sits at offsets 0 to 9fff of the window.
// RL15: control registers sit at offsets ffe0 to ffff of the window.
// RL16: 128K window, nothing from A17 up decoded, so it aliases.
// RL17: one extra top address bit reaches the larger display memory.
// RL18: panel power enable output is active high.
// RL19: optional divide by two of the pixel source clock.
// RL20: board glue selects on any slot access, memory or attribute.
// RL21: select and strobes pass two flops on the host bus clock.
// RL22: idle select leaves hold-off released and data lines undriven.
module strobe_host_port #(
    parameter int MEM_WORDS = strobe_port_pkg::MEM_WORDS_DOC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        host_bus_clock_i,
    input  wire logic        pixel_source_clock_i,
    input  wire logic [2:0]  config_straps_i,
    input  wire logic        endian_strap_i,
    input  wire logic        bus_status_n_i,
    input  wire logic [15:0] addr_in_i,
    input  wire logic        top_addr_bit_i,
    input  wire logic [15:0] data_in_i,
    output logic      [15:0] data_out_o,
    output logic             data_oe_o,
    input  wire logic        chip_select_n_i,
    input  wire logic        read_enable_n_i,
    input  wire logic        write_enable_n_i,
    input  wire logic        high_byte_enable_n_i,
    output logic             hold_off_n_o,
    input  wire logic        refresh_req_i,
    input  wire logic [15:0] refresh_addr_i,
    output logic      [15:0] refresh_data_o,
    output logic             refresh_valid_o,
    output logic             panel_power_enable_o,
    output logic             pixel_clk_o,
    output logic             port_ready_o,
    output logic             big_endian_o
);

    if (MEM_WORDS < 2 * int'(strobe_port_pkg::MEM_HALF_WORDS) || MEM_WORDS > 65536)
    begin : g_check
        $error("MEM_WORDS must cover both halves of display memory");
    end

    // system domain: strap capture after reset release
    strobe_port_pkg::strap_t strap_sync;
    strobe_port_pkg::strap_t strap_r;
    logic [1:0]              catch_cnt_r;

    level_sync #(
        .WIDTH     (5),
        .RESET_VAL (5'h00)
    ) u_strap_sync (
        .clk_i   (clk_sys_i),
        .reset_i (reset_i),
        .d_i     ({bus_status_n_i, endian_strap_i, config_straps_i}),
        .q_o     (strap_sync)
    );

    // straps are static pins, so the synchronised value is caught
    // for a few cycles at release rather than under the reset itself
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            catch_cnt_r <= 2'h0;
            strap_r     <= '0;
        end
        else if (catch_cnt_r != strobe_port_pkg::CATCH_LAST)
        begin
            catch_cnt_r <= catch_cnt_r + 2'h1;
            strap_r     <= strap_sync; // [RL1] [RL3]
        end
    end

    wire strap_done  = (catch_cnt_r == strobe_port_pkg::CATCH_LAST);
    // only the split strobe flavour is served; bus status selects it
    wire split_mode  = strap_done && (strap_r.mode == strobe_port_pkg::STRAP_GENERIC)
                       && strap_r.bus_status_n; // [RL1] [RL2]

    assign port_ready_o = split_mode;
    assign big_endian_o = strap_r.big_endian;

    // host domain: synchronised select and strobes
    logic [2:0]                   strobe_sync;
    logic [1:0]                   cfg_h;
    logic                         ack_h;
    strobe_port_pkg::host_state_t host_state_r;
    strobe_port_pkg::host_state_t host_state_nxt;
    strobe_port_pkg::host_req_t   req_r;
    logic                         req_tog_r;
    logic                         ack_seen_r;
    logic [15:0]                  host_rdata_r;
    logic [15:0]                  sys_rdata_r;
    logic                         sys_ack_tog;

    level_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h7)
    ) u_strobe_sync (
        .clk_i   (host_bus_clock_i),
        .reset_i (reset_i),
        .d_i     ({chip_select_n_i, read_enable_n_i, write_enable_n_i}),
        .q_o     (strobe_sync) // [RL4] [RL5] [RL21]
    );

    level_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h0)
    ) u_cfg_sync (
        .clk_i   (host_bus_clock_i),
        .reset_i (reset_i),
        .d_i     ({split_mode, strap_r.big_endian, sys_ack_tog}),
        .q_o     ({cfg_h, ack_h})
    );

    // read/write and bus status lines are never looked at during cycles
    wire port_en_h = cfg_h[1];
    wire swap_h    = cfg_h[0];
    wire sel_h     = port_en_h && !strobe_sync[2]; // [RL13] [RL22]
    wire rd_act    = sel_h && !strobe_sync[1];
    wire wr_act    = sel_h && !strobe_sync[0]; // [RL9]
    wire any_act   = rd_act || wr_act;
    wire ack_edge  = (ack_h != ack_seen_r);
    // big endian swaps the byte lanes of data and byte enables
    wire [15:0] wdata_lane = swap_h ? {data_in_i[7:0], data_in_i[15:8]} : data_in_i; // [RL3]
    wire [1:0]  be_raw     = {!high_byte_enable_n_i, !addr_in_i[0]}; // [RL9]
    wire [1:0]  be_lane    = swap_h ? {be_raw[0], be_raw[1]} : be_raw;
    wire [15:0] rdata_lane = swap_h ? {sys_rdata_r[7:0], sys_rdata_r[15:8]} : sys_rdata_r;

    always_comb
    begin
        host_state_nxt = host_state_r;
        unique case (host_state_r)
            strobe_port_pkg::HOST_IDLE:
                if (any_act)
                begin
                    host_state_nxt = strobe_port_pkg::HOST_WAIT;
                end
            strobe_port_pkg::HOST_WAIT:
                if (ack_edge)
                begin
                    host_state_nxt = strobe_port_pkg::HOST_DONE;
                end
            strobe_port_pkg::HOST_DONE:
                if (!any_act)
                begin
                    host_state_nxt = strobe_port_pkg::HOST_IDLE;
                end
            default:
                host_state_nxt = strobe_port_pkg::HOST_IDLE;
        endcase
    end

    // address and data are sampled only once the synchronised strobe is
    // seen, by which time the host has held them stable for two edges
    always_ff @(posedge host_bus_clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            host_state_r <= strobe_port_pkg::HOST_IDLE;
            req_r        <= '0;
            req_tog_r    <= 1'b0;
            ack_seen_r   <= 1'b0;
            host_rdata_r <= 16'h0000;
        end
        else
        begin
            host_state_r <= host_state_nxt;
            if (host_state_r == strobe_port_pkg::HOST_IDLE && any_act)
            begin
                req_r     <= '{top: top_addr_bit_i, addr: addr_in_i, wdata: wdata_lane,
                               be: be_lane, write: wr_act}; // [RL6] [RL17]
                req_tog_r <= !req_tog_r;
            end
            if (host_state_r == strobe_port_pkg::HOST_WAIT && ack_edge)
            begin
                ack_seen_r   <= ack_h;
                host_rdata_r <= rdata_lane;
            end
        end
    end

    // hold off until the system side has answered, released while idle
    assign hold_off_n_o = !(any_act && host_state_r != strobe_port_pkg::HOST_DONE); // [RL11] [RL12] [RL22]
    assign data_oe_o    = rd_act && !req_r.write
                          && host_state_r == strobe_port_pkg::HOST_DONE; // [RL6] [RL22]
    assign data_out_o   = host_rdata_r;

    // system domain: request crossing and arbitration
    logic req_s;
    logic req_seen_r;

    level_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_req_sync (
        .clk_i   (clk_sys_i),
        .reset_i (reset_i),
        .d_i     (req_tog_r),
        .q_o     (req_s)
    );

    wire pending = (req_s != req_seen_r);
    // refresh wins; the host waits behind it with hold-off asserted
    wire grant   = pending && !refresh_req_i; // [RL12]

    // window decode: A17 and up never reach the port, so it aliases
    wire        sel_mem  = (req_r.addr <= strobe_port_pkg::MEM_END); // [RL14] [RL16]
    wire        sel_reg  = !req_r.top && (req_r.addr >= strobe_port_pkg::REG_BASE); // [RL15]
    wire [15:0] mem_idx  = req_r.top ? strobe_port_pkg::MEM_HALF_WORDS + {1'b0, req_r.addr[15:1]}
                                     : {1'b0, req_r.addr[15:1]}; // [RL17]
    wire [3:0]  reg_idx  = req_r.addr[4:1];
    wire        mem_we   = grant && req_r.write && sel_mem;
    wire        reg_we   = grant && req_r.write && sel_reg
                           && reg_idx != strobe_port_pkg::REG_STATUS;

    logic [15:0] mem_rd;
    logic [15:0] ref_rd;

    for (genvar b = 0; b < 2; b++)
    begin : g_byte
        logic [7:0] mem_b [MEM_WORDS];
        logic [7:0] reg_byte_r [strobe_port_pkg::REG_WORDS];

        // byte write enables keep the other lane of the word untouched
        always_ff @(posedge clk_sys_i)
        begin
            if (mem_we && req_r.be[b])
            begin
                mem_b[mem_idx] <= req_r.wdata[b*8 +: 8]; // [RL9]
            end
        end

        always_ff @(posedge clk_sys_i or posedge reset_i)
        begin
            if (reset_i)
            begin
                for (int i = 0; i < strobe_port_pkg::REG_WORDS; i++)
                begin
                    reg_byte_r[i] <= strobe_port_pkg::CONTROL_RESET[b*8 +: 8];
                end
            end
            else if (reg_we && req_r.be[b])
            begin
                reg_byte_r[reg_idx] <= req_r.wdata[b*8 +: 8];
            end
        end

        assign mem_rd[b*8 +: 8] = mem_b[mem_idx];
        assign ref_rd[b*8 +: 8] = mem_b[refresh_addr_i];
    end

    wire [15:0] status_word = {11'h000, strap_r};
    wire [15:0] reg_rd      = (reg_idx == strobe_port_pkg::REG_STATUS) ? status_word
                              : {g_byte[1].reg_byte_r[reg_idx], g_byte[0].reg_byte_r[reg_idx]};
    // unmapped offsets read as zero and swallow writes
    wire [15:0] rd_word     = sel_mem ? mem_rd : (sel_reg ? reg_rd : 16'h0000);
    wire [15:0] control     = {g_byte[1].reg_byte_r[strobe_port_pkg::REG_CONTROL],
                               g_byte[0].reg_byte_r[strobe_port_pkg::REG_CONTROL]};

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            req_seen_r           <= 1'b0;
            sys_ack_tog          <= 1'b0;
            sys_rdata_r          <= 16'h0000;
            refresh_data_o       <= 16'h0000;
            refresh_valid_o      <= 1'b0;
            panel_power_enable_o <= 1'b0;
        end
        else
        begin
            refresh_valid_o      <= refresh_req_i;
            panel_power_enable_o <= control[strobe_port_pkg::CTL_PANEL_POWER]; // [RL18]
            if (refresh_req_i)
            begin
                refresh_data_o <= ref_rd;
            end
            // read data settles with the toggle; host samples it later
            if (grant)
            begin
                req_seen_r  <= req_s;
                sys_ack_tog <= !sys_ack_tog;
                sys_rdata_r <= rd_word;
            end
        end
    end

    // pixel domain: optional divide by two
    logic div_sel_p;
    logic div_r;

    level_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_div_sync (
        .clk_i   (pixel_source_clock_i),
        .reset_i (reset_i),
        .d_i     (control[strobe_port_pkg::CTL_PIXEL_DIV]),
        .q_o     (div_sel_p)
    );

    always_ff @(posedge pixel_source_clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            div_r <= 1'b0;
        end
        else
        begin
            div_r <= !div_r; // [RL19]
        end
    end

    // plain mux: switching the divider mid-frame can give one short pulse
    assign pixel_clk_o = div_sel_p ? div_r : pixel_source_clock_i; // [RL19]

endmodule

// ==== sim/strobe_port_sva.sv ====
/*
 * timing checks on the pins of the split-strobe host port.
 * assumes a bind onto strobe_host_port; straps stay steady outside reset.
 */
module strobe_port_sva (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic        host_bus_clock_i,
    input wire logic [2:0]  config_straps_i,
    input wire logic        endian_strap_i,
    input wire logic        bus_status_n_i,
    input wire logic        chip_select_n_i,
    input wire logic        read_enable_n_i,
    input wire logic        write_enable_n_i,
    input wire logic [15:0] data_out_o,
    input wire logic        data_oe_o,
    input wire logic        hold_off_n_o,
    input wire logic        refresh_req_i,
    input wire logic        refresh_valid_o,
    input wire logic        port_ready_o,
    input wire logic        big_endian_o
);
    timeunit 1ns;
    timeprecision 1ps;
    chk_idle_quiet: assert property (
        @(posedge host_bus_clock_i) disable iff (reset_i)
        chip_select_n_i [*4] |-> !data_oe_o && hold_off_n_o)
        else $error("port active with select idle");
    chk_write_undriven: assert property (
        @(posedge host_bus_clock_i) disable iff (reset_i)
        (!write_enable_n_i && read_enable_n_i) [*4] |-> !data_oe_o)
        else $error("data driven during a write");
    // one flop fewer would let hold-off fall a cycle early
    chk_sync_depth: assert property (
        @(posedge host_bus_clock_i) disable iff (reset_i)
        $fell(hold_off_n_o) |-> !$past(chip_select_n_i, 1) && !$past(chip_select_n_i, 2))
        else $error("hold-off ahead of synchronised select");
    chk_read_release: assert property (
        @(posedge host_bus_clock_i) disable iff (reset_i)
        $rose(hold_off_n_o) && !read_enable_n_i |-> data_oe_o)
        else $error("read released without data");
    chk_oe_cause: assert property (
        @(posedge host_bus_clock_i) disable iff (reset_i)
        data_oe_o |-> !$past(read_enable_n_i, 2) && !$past(chip_select_n_i, 2))
        else $error("data driven without a read");
    chk_data_steady: assert property (
        @(posedge host_bus_clock_i) disable iff (reset_i)
        data_oe_o && $past(data_oe_o) |-> $stable(data_out_o))
        else $error("read data moved while driven");
    chk_not_ready: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !port_ready_o |-> hold_off_n_o && !data_oe_o)
        else $error("port answered before it was ready");
    chk_ready_straps: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        port_ready_o |-> config_straps_i == 3'h7 && bus_status_n_i
        && big_endian_o == endian_strap_i)
        else $error("ready with wrong straps");
    chk_refresh_lat: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        refresh_valid_o == $past(refresh_req_i))
        else $error("refresh valid not one cycle after request");
    cov_read_done: cover property (@(posedge host_bus_clock_i) $rose(hold_off_n_o) && data_oe_o);
    cov_contend: cover property (@(posedge clk_sys_i) refresh_req_i && !hold_off_n_o);
    cov_big_end: cover property (@(posedge clk_sys_i) port_ready_o && big_endian_o);
endmodule

// ==== sim/host_model.sv ====
/*
 * host processor with its decode glue, running strobe cycles on the port.
 * assumes the bench resolves the data wire from both drivers.
 */
module host_model (
    input wire logic        clk_i,
    input wire logic        hold_off_n_i,
    input wire logic [15:0] data_bus_i,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            we_n_o,
    output logic            hbe_n_o,
    output logic            top_o,
    output logic [15:0]     addr_o,
    output logic [15:0]     data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {cs_n_o, rd_n_o, we_n_o, hbe_n_o, top_o} = 5'h1e;
        {addr_o, data_o} = 32'h00000000;
    end
    // ok low means the port never held off, the cycle was refused
    task automatic acc(input logic wr, tp, input logic [15:0] a, d, input logic hb,
                       output logic [15:0] q, output logic ok);
        int n;
        @(negedge clk_i);
        top_o = tp;
        addr_o = a;
        hbe_n_o = hb;
        data_o = wr ? d : ~data_o;
        cs_n_o = 1'b0;
        rd_n_o = wr;
        we_n_o = !wr;
        for (n = 0; n < 40 && hold_off_n_i; n++)
            @(negedge clk_i);
        ok = n < 40;
        for (n = 0; n < 400 && !hold_off_n_i; n++)
            @(negedge clk_i);
        @(posedge clk_i);
        q = data_bus_i;
        @(negedge clk_i);
        {cs_n_o, rd_n_o, we_n_o} = 3'h7;
        // released lines must not keep the last value
        data_o = ~data_o;
        repeat (4)
            @(negedge clk_i);
    endtask
endmodule

// ==== sim/testbench.sv ====
/*
 * self-checking bench for the split-strobe host port.
 * assumes host_model as the far side; refresh is driven here.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0, host_bus_clock_i = 1'b0, pixel_source_clock_i = 1'b0;
    logic        reset_i = 1'b1, endian_strap_i = 1'b0, bus_status_n_i = 1'b1;
    logic        refresh_req_i = 1'b0, ok;
    logic [2:0]  config_straps_i = 3'h7;
    logic [15:0] refresh_addr_i = 16'h0000, q;
    wire logic   top_addr_bit_i, chip_select_n_i, read_enable_n_i;
    wire logic   write_enable_n_i, high_byte_enable_n_i;
    wire logic [15:0] addr_in_i, data_in_i, host_data;
    logic [15:0] data_out_o, refresh_data_o;
    logic        data_oe_o, hold_off_n_o, refresh_valid_o, panel_power_enable_o;
    logic        pixel_clk_o, port_ready_o, big_endian_o;
    int          num_errors = 0, n_tests = 0, cyc = 0, pcnt = 0;

    strobe_host_port i_strobe_host_port (
        .clk_sys_i, .reset_i, .host_bus_clock_i, .pixel_source_clock_i,
        .config_straps_i, .endian_strap_i, .bus_status_n_i, .addr_in_i,
        .top_addr_bit_i, .data_in_i, .data_out_o, .data_oe_o, .chip_select_n_i,
        .read_enable_n_i, .write_enable_n_i, .high_byte_enable_n_i, .hold_off_n_o,
        .refresh_req_i, .refresh_addr_i, .refresh_data_o, .refresh_valid_o,
        .panel_power_enable_o, .pixel_clk_o, .port_ready_o, .big_endian_o
    );
    host_model i_host_model (
        .clk_i(host_bus_clock_i), .hold_off_n_i(hold_off_n_o), .data_bus_i(data_in_i),
        .cs_n_o(chip_select_n_i), .rd_n_o(read_enable_n_i), .we_n_o(write_enable_n_i),
        .hbe_n_o(high_byte_enable_n_i), .top_o(top_addr_bit_i), .addr_o(addr_in_i),
        .data_o(host_data)
    );
    assign data_in_i = data_oe_o ? data_out_o : host_data;

    always #25 clk_sys_i = ~clk_sys_i;
    always #7.5 host_bus_clock_i = ~host_bus_clock_i;
    always #5 pixel_source_clock_i = ~pixel_source_clock_i;
    always @(posedge pixel_clk_o) pcnt++;
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input string s, input logic [15:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", s, e, g);
            num_errors++;
        end
    endtask
    task automatic rst(input logic [2:0] m, input logic e, b);
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        config_straps_i = m;
        endian_strap_i = e;
        bus_status_n_i = b;
        repeat (8)
            @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (40)
            @(negedge clk_sys_i);
    endtask
    task automatic wr(input logic t, input logic [15:0] a, d, input logic hb);
        i_host_model.acc(1'b1, t, a, d, hb, q, ok);
    endtask
    task automatic rd(input logic t, input logic [15:0] a, e, input string s);
        i_host_model.acc(1'b0, t, a, 16'h0000, 1'b0, q, ok);
        chk(s, e, q);
    endtask
    task automatic rf(input logic [15:0] i, e, input string s);
        @(negedge clk_sys_i);
        refresh_req_i = 1'b1;
        refresh_addr_i = i;
        @(negedge clk_sys_i);
        refresh_req_i = 1'b0;
        chk(s, e, refresh_data_o);
        chk("refresh valid", 16'h0001, {15'h0000, refresh_valid_o});
    endtask
    // 400 ns of a 10 ns source: 40 edges plain, 20 halved, one either way
    task automatic pix(input int lo, input string s);
        int c;
        c = pcnt;
        #400;
        chk(s, 16'h0001, {15'h0000, pcnt - c >= lo && pcnt - c <= lo + 2});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        rst(3'h6, 1'b0, 1'b1);
        chk("ready bad mode", 16'h0000, {15'h0000, port_ready_o});
        i_host_model.acc(1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, q, ok);
        chk("refused", 16'h0000, {15'h0000, ok});
        rst(3'h7, 1'b0, 1'b0);
        chk("ready status low", 16'h0000, {15'h0000, port_ready_o});
        $display("test straps done");
        rst(3'h7, 1'b0, 1'b1);
        chk("ready", 16'h0001, {15'h0000, port_ready_o});
        chk("endian", 16'h0000, {15'h0000, big_endian_o});
        chk("power reset", 16'h0000, {15'h0000, panel_power_enable_o});
        wr(1'b0, 16'h0000, 16'h1234, 1'b0);
        rf(16'h0000, 16'h1234, "little lanes");
        rd(1'b0, 16'h0000, 16'h1234, "word 0");
        wr(1'b0, 16'h9ffe, 16'hbeef, 1'b0);
        rf(16'h4fff, 16'hbeef, "last word");
        wr(1'b0, 16'h0000, 16'hcdef, 1'b1);
        wr(1'b0, 16'h0001, 16'h7700, 1'b0);
        rd(1'b0, 16'h0000, 16'h77ef, "byte lanes");
        wr(1'b1, 16'h0002, 16'h5a5a, 1'b0);
        rf(16'h5001, 16'h5a5a, "upper half");
        wr(1'b0, 16'ha000, 16'hffff, 1'b0);
        rd(1'b0, 16'ha000, 16'h0000, "unmapped");
        rd(1'b1, 16'hffe2, 16'h0000, "upper regs");
        wr(1'b0, 16'hffe2, 16'h0000, 1'b0);
        rd(1'b0, 16'hffe2, 16'h0017, "status");
        wr(1'b0, 16'hfffe, 16'h0f0f, 1'b0);
        rd(1'b0, 16'hfffe, 16'h0f0f, "last reg");
        $display("test map done");
        wr(1'b0, 16'hffe0, 16'h0001, 1'b0);
        chk("power on", 16'h0001, {15'h0000, panel_power_enable_o});
        pix(39, "pixel plain");
        wr(1'b0, 16'hffe0, 16'h0003, 1'b0);
        pix(19, "pixel halved");
        wr(1'b0, 16'hffe0, 16'h0000, 1'b0);
        chk("power off", 16'h0000, {15'h0000, panel_power_enable_o});
        $display("test control done");
        @(negedge clk_sys_i);
        refresh_req_i = 1'b1;
        fork
            wr(1'b0, 16'h0010, 16'h4321, 1'b0);
            begin
                #2000;
                chk("held off", 16'h0000, {15'h0000, hold_off_n_o});
                refresh_req_i = 1'b0;
            end
        join
        rd(1'b0, 16'h0010, 16'h4321, "after refresh");
        $display("test contention done");
        rst(3'h7, 1'b1, 1'b1);
        chk("endian big", 16'h0001, {15'h0000, big_endian_o});
        wr(1'b0, 16'h0000, 16'h1234, 1'b0);
        rf(16'h0000, 16'h3412, "big lanes");
        rd(1'b0, 16'h0000, 16'h1234, "big word");
        rd(1'b0, 16'hffe2, 16'h1f00, "big status");
        $display("test endian done");
        summarize();
    end
endmodule

bind strobe_host_port strobe_port_sva i_strobe_port_sva (
    .clk_sys_i, .reset_i, .host_bus_clock_i, .config_straps_i, .endian_strap_i,
    .bus_status_n_i, .chip_select_n_i, .read_enable_n_i, .write_enable_n_i,
    .data_out_o, .data_oe_o, .hold_off_n_o, .refresh_req_i, .refresh_valid_o,
    .port_ready_o, .big_endian_o
);
